// ==== shared/aas_pkg.sv ====
/*
 package for the accumulator add-with-shift datapath: modes, memory
 placements, apb map, field positions, reset values, cycle figures.
 assumes a single 10 MHz pclk domain.
*/
package aas_pkg;

    // addressing forms
    typedef enum logic [1:0]
    {
        AAS_FORM_DIRECT  = 2'b00,
        AAS_FORM_SHORT   = 2'b01,
        AAS_FORM_LONG    = 2'b10,
        AAS_FORM_NONE    = 2'b11
    } aas_form_type;

    // memory placement
    typedef enum logic [1:0]
    {
        AAS_MEM_ROM      = 2'b00,
        AAS_MEM_DUAL     = 2'b01,
        AAS_MEM_SINGLE   = 2'b10,
        AAS_MEM_EXT      = 2'b11
    } aas_mem_type;

    // execution states
    typedef enum logic [1:0]
    {
        AAS_ST_IDLE      = 2'b00,
        AAS_ST_WAIT      = 2'b01,
        AAS_ST_DONE      = 2'b10
    } aas_state_type;

    // apb register offsets
    localparam logic [11:0] AAS_OFS_CTRL   = 12'h000;
    localparam logic [11:0] AAS_OFS_STATUS = 12'h004;
    localparam logic [11:0] AAS_OFS_ACC    = 12'h008;
    localparam logic [11:0] AAS_OFS_WAIT   = 12'h00c;

    // control fields
    localparam int AAS_CTRL_SIGN_BIT = 0;
    localparam int AAS_CTRL_SAT_BIT  = 1;
    // status fields
    localparam int AAS_ST_CARRY_BIT = 0;
    localparam int AAS_ST_OV_BIT    = 1;
    localparam int AAS_ST_BUSY_BIT  = 2;
    // wait-state register fields
    localparam int AAS_WAIT_P_LSB   = 0;
    localparam int AAS_WAIT_D_LSB   = 8;

    // reset values
    localparam logic [31:0] AAS_ACC_RST   = 32'h0000_0000;
    localparam logic [1:0]  AAS_CTRL_RST  = 2'h0;
    localparam logic [7:0]  AAS_WAIT_RST  = 8'h00;

    // shift giving carry-only-set behaviour
    localparam logic [4:0]  AAS_SHIFT_CARRY_HOLD = 5'h10;

    // base cycle figures
    localparam logic [15:0] AAS_CYC_ONE = 16'h0001;
    localparam logic [15:0] AAS_CYC_TWO = 16'h0002;

endpackage : aas_pkg

// ==== rtl/aas_cycles.sv ====
/*
 cycle-count calculator for one add, single or repeated.
 assumes p and d are external wait figures supplied by software.
*/
`timescale 1ns/1ps
module aas_cycles
import aas_pkg::*;
(
    // instruction shape
    input  wire aas_pkg::aas_form_type form,
    input  wire aas_pkg::aas_mem_type  prog_mem,
    input  wire aas_pkg::aas_mem_type  opnd_mem,
    input  wire logic                  same_block,
    input  wire logic [7:0]            rpt_count,
    // wait figures
    input  wire logic [7:0]            wait_p,
    input  wire logic [7:0]            wait_d,
    // result
    output logic [15:0]                cycles
);
    import aas_pkg::*;

    logic [15:0] n;
    logic [15:0] p;
    logic [15:0] d;
    logic        repeat_next_instruction;
    logic        pext;
    logic        dext;

    assign n    = {8'h00, rpt_count} + AAS_CYC_ONE;
    assign p    = {8'h00, wait_p};
    assign d    = {8'h00, wait_d};
    assign repeat_next_instruction  = rpt_count != 8'h00;
    assign pext = prog_mem == AAS_MEM_EXT;
    assign dext = opnd_mem == AAS_MEM_EXT;

    always_comb
    begin
        cycles = AAS_CYC_ONE;
        unique case (form)
            AAS_FORM_SHORT:
                cycles = pext ? AAS_CYC_ONE + p : AAS_CYC_ONE;
            AAS_FORM_LONG:
                cycles = pext ? AAS_CYC_TWO + p + p : AAS_CYC_TWO;
            AAS_FORM_DIRECT:
            begin
                if (!repeat_next_instruction)
                begin
                    if (pext && dext)
                        cycles = AAS_CYC_TWO + d + p;
                    else if (dext)
                        cycles = AAS_CYC_ONE + d;
                    else if (pext)
                        cycles = AAS_CYC_ONE + p;
                    else if (same_block && prog_mem == AAS_MEM_SINGLE
                             && opnd_mem == AAS_MEM_SINGLE)
                        cycles = AAS_CYC_TWO;
                    else
                        cycles = AAS_CYC_ONE;
                end
                else
                begin
                    if (pext && dext)
                        cycles = 16'((n + AAS_CYC_ONE + p)
                                 + 16'(n * d));
                    else if (dext)
                        cycles = 16'(n + n * d);
                    else if (pext)
                        cycles = n + p;
                    else if (same_block && prog_mem == AAS_MEM_SINGLE
                             && opnd_mem == AAS_MEM_SINGLE)
                        cycles = n + AAS_CYC_ONE;
                    else
                        cycles = n;
                end
            end
            default:
                cycles = AAS_CYC_ONE;
        endcase
    end

endmodule : aas_cycles

// ==== rtl/aas_top.sv ====
/*
 accumulator add-with-shift datapath with apb control/status registers.
 assumes the decoder gives one start pulse per add with operand stable
 until done; in direct form repeat count adds n = rpt_count+1 times.
*/
// Functional notes
//- operand shifts left, zero fill low, high fill by sign mode.
//- the sum replaces the accumulator, except on overflow in saturation mode.
//- short immediate ignores sign mode and is zero extended.
//- for shifts other than 16, carry equals the carry out.
//- for a shift of 16, carry is only set, never cleared.
//- single direct add takes 1, 2, 1+p, 1+d or 2+d+p cycles.
//- repeated add takes n, n+1, n+p, n+nd or n+1+p+nd cycles.
//- short immediate takes 1 or 1+p cycles.
//- long immediate takes 2 or 2+2p cycles.
`timescale 1ns/1ps
module aas_top
import aas_pkg::*;
(
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    // decoder request
    input  wire logic                  start,
    input  wire aas_pkg::aas_form_type form,
    input  wire logic [15:0]           operand,
    input  wire logic [3:0]            shift,
    input  wire logic                  shift16,
    input  wire logic [7:0]            rpt_count,
    input  wire aas_pkg::aas_mem_type  prog_mem,
    input  wire aas_pkg::aas_mem_type  opnd_mem,
    input  wire logic                  same_block,
    // results
    output logic                       busy,
    output logic                       done,
    output logic [31:0]                accumulator,
    output logic                       carry_flag,
    output logic                       overflow_flag
);
    import aas_pkg::*;

    aas_state_type state_r;
    logic [31:0]   acc_r;
    logic          carry_r;
    logic          ov_r;
    logic          sign_mode_r;
    logic          sat_mode_r;
    logic [7:0]    wait_p_r;
    logic [7:0]    wait_d_r;
    logic [15:0]   cnt_r;
    logic [15:0]   cycles;
    logic [8:0]    adds_r;
    logic          done_r;
    aas_form_type  form_r;
    logic [15:0]   opnd_r;
    logic [4:0]    sh_r;
    logic [31:0]   shifted;
    logic [32:0]   sum;
    logic          sov;
    logic [31:0]   acc_nxt;
    logic          carry_nxt;
    logic          fire;
    logic          apb_wr;
    logic          hit;

    function automatic logic [31:0] shl_ext(input logic [15:0] v,
                                            input logic [4:0] s,
                                            input logic       sx);
        logic [31:0] e;
        e = sx ? {{16{v[15]}}, v} : {16'h0000, v};
        return e << s;
    endfunction : shl_ext

    aas_cycles u_cycles
    (
        .form       (form),
        .prog_mem   (prog_mem),
        .opnd_mem   (opnd_mem),
        .same_block (same_block),
        .rpt_count  (rpt_count),
        .wait_p     (wait_p_r),
        .wait_d     (wait_d_r),
        .cycles     (cycles)
    );

    assign fire = start && state_r == AAS_ST_IDLE;

    assign shifted = (form_r == AAS_FORM_SHORT)
                     ? {16'h0000, opnd_r}
                     : shl_ext(opnd_r, sh_r, sign_mode_r);
    assign sum = {1'b0, acc_r} + {1'b0, shifted};
    assign sov = (acc_r[31] == shifted[31]) && (sum[31] != acc_r[31]);

    always_comb
    begin
        acc_nxt = sum[31:0];
        if (sov && sat_mode_r)
            acc_nxt = acc_r[31] ? 32'h8000_0000 : 32'h7fff_ffff;
        if (sh_r == AAS_SHIFT_CARRY_HOLD && form_r != AAS_FORM_SHORT)
            carry_nxt = carry_r | sum[32];
        else
            carry_nxt = sum[32];
    end

    // sequencing
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r <= AAS_ST_IDLE;
            cnt_r   <= 16'h0000;
            adds_r  <= 9'h000;
            form_r  <= AAS_FORM_NONE;
            opnd_r  <= 16'h0000;
            sh_r    <= 5'h00;
            done_r  <= 1'b0;
        end
        else
        begin
            done_r <= 1'b0;
            unique case (state_r)
                AAS_ST_IDLE:
                    if (fire)
                    begin
                        cnt_r   <= cycles;
                        adds_r  <= {1'b0, rpt_count} + 9'h001;
                        form_r  <= form;
                        opnd_r  <= operand;
                        sh_r    <= shift16 ? AAS_SHIFT_CARRY_HOLD
                                           : {1'b0, shift};
                        state_r <= AAS_ST_WAIT;
                    end
                AAS_ST_WAIT:
                begin
                    cnt_r <= cnt_r - 16'h0001;
                    if (cnt_r == AAS_CYC_ONE)
                    begin
                        done_r  <= 1'b1;
                        state_r <= AAS_ST_IDLE;
                    end
                end
                default:
                    state_r <= AAS_ST_IDLE;
            endcase
        end
    end

    // accumulate: repeats add once per cycle, leftover cycles stall
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acc_r   <= AAS_ACC_RST;
            carry_r <= 1'b0;
            ov_r    <= 1'b0;
        end
        else if (apb_wr && paddr == AAS_OFS_ACC)
            acc_r <= pwdata;
        else if (apb_wr && paddr == AAS_OFS_STATUS)
        begin
            carry_r <= pwdata[AAS_ST_CARRY_BIT];
            ov_r    <= pwdata[AAS_ST_OV_BIT];
        end
        else if (state_r == AAS_ST_WAIT && cnt_r <= {7'h00, adds_r})
        begin
            acc_r   <= acc_nxt;
            carry_r <= carry_nxt;
            if (sov)
                ov_r <= 1'b1;
        end
    end

    // apb control registers
    assign apb_wr = psel && penable && pwrite;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sign_mode_r <= AAS_CTRL_RST[AAS_CTRL_SIGN_BIT];
            sat_mode_r  <= AAS_CTRL_RST[AAS_CTRL_SAT_BIT];
            wait_p_r <= AAS_WAIT_RST;
            wait_d_r <= AAS_WAIT_RST;
        end
        else if (apb_wr && paddr == AAS_OFS_CTRL)
        begin
            sign_mode_r <= pwdata[AAS_CTRL_SIGN_BIT];
            sat_mode_r  <= pwdata[AAS_CTRL_SAT_BIT];
        end
        else if (apb_wr && paddr == AAS_OFS_WAIT)
        begin
            wait_p_r <= pwdata[AAS_WAIT_P_LSB +: 8];
            wait_d_r <= pwdata[AAS_WAIT_D_LSB +: 8];
        end
    end

    assign hit = paddr == AAS_OFS_CTRL || paddr == AAS_OFS_STATUS
              || paddr == AAS_OFS_ACC || paddr == AAS_OFS_WAIT;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;

    always_comb
    begin
        prdata = 32'h0000_0000;
        unique case (paddr)
            AAS_OFS_CTRL:
            begin
                prdata[AAS_CTRL_SIGN_BIT] = sign_mode_r;
                prdata[AAS_CTRL_SAT_BIT]  = sat_mode_r;
            end
            AAS_OFS_STATUS:
            begin
                prdata[AAS_ST_CARRY_BIT] = carry_r;
                prdata[AAS_ST_OV_BIT]    = ov_r;
                prdata[AAS_ST_BUSY_BIT]  = busy;
            end
            AAS_OFS_ACC:
                prdata = acc_r;
            AAS_OFS_WAIT:
                prdata = {16'h0000, wait_d_r, wait_p_r};
            default:
                prdata = 32'h0000_0000;
        endcase
    end

    assign busy          = state_r != AAS_ST_IDLE;
    assign done          = done_r;
    assign accumulator   = acc_r;
    assign carry_flag    = carry_r;
    assign overflow_flag = ov_r;

    a_carry_hold:
    assert property (@(posedge pclk) disable iff (!presetn)
        (carry_r && state_r == AAS_ST_WAIT && sh_r == AAS_SHIFT_CARRY_HOLD
         && form_r != AAS_FORM_SHORT && !apb_wr) |=> carry_r)
        else $error("carry cleared on shift of 16");
    a_carry_follow:
    assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == AAS_ST_WAIT && cnt_r == AAS_CYC_ONE && !apb_wr
         && sh_r != AAS_SHIFT_CARRY_HOLD) |=> carry_r == $past(sum[32]))
        else $error("carry does not follow carry out");
    a_sum_write:
    assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == AAS_ST_WAIT && cnt_r == AAS_CYC_ONE && !apb_wr && !sov)
        |=> acc_r == $past(sum[31:0]))
        else $error("accumulator not replaced by sum");
    a_short_zero:
    assert property (@(posedge pclk) disable iff (!presetn)
        form_r == AAS_FORM_SHORT |-> shifted[31:16] == 16'h0000)
        else $error("short operand extended");
    a_sat_value:
    assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == AAS_ST_WAIT && cnt_r == AAS_CYC_ONE && !apb_wr
         && sov && sat_mode_r) |=> ov_r && (acc_r == 32'h7fff_ffff
                                           || acc_r == 32'h8000_0000))
        else $error("no saturation on overflow");
    a_single_one:
    assert property (@(posedge pclk) disable iff (!presetn)
        (fire && form == AAS_FORM_DIRECT && rpt_count == 8'h00
         && prog_mem == AAS_MEM_ROM && opnd_mem == AAS_MEM_DUAL)
        |=> !done ##1 done)
        else $error("single on-chip add not one cycle");
    a_rpt_n:
    assert property (@(posedge pclk) disable iff (!presetn)
        (fire && form == AAS_FORM_DIRECT && rpt_count == 8'h02
         && prog_mem == AAS_MEM_ROM && opnd_mem == AAS_MEM_DUAL)
        |=> !done ##1 !done ##1 !done ##1 done)
        else $error("repeat of three not three cycles");
    a_long_two:
    assert property (@(posedge pclk) disable iff (!presetn)
        (fire && form == AAS_FORM_LONG && prog_mem == AAS_MEM_ROM)
        |=> !done ##1 !done ##1 done)
        else $error("long immediate not two cycles");
    a_short_one:
    assert property (@(posedge pclk) disable iff (!presetn)
        (fire && form == AAS_FORM_SHORT && prog_mem != AAS_MEM_EXT)
        |=> !done ##1 done)
        else $error("short immediate not one cycle");
    a_shift_fill:
    assert property (@(posedge pclk) disable iff (!presetn)
        (form_r != AAS_FORM_SHORT && sh_r >= 5'h04)
        |-> shifted[3:0] == 4'h0)
        else $error("low bits not zero filled");

    c_shift16: cover property (@(posedge pclk) fire && shift16);
    c_repeat: cover property (@(posedge pclk) fire && rpt_count != 8'h00);
    c_saturate: cover property (@(posedge pclk) sov && sat_mode_r);

endmodule : aas_top

// ==== verification/aas_dec_model.sv ====
/*
 decoder and data memory stand-in issuing queued add requests.
 assumes start is taken at an edge where busy is low.
*/
`timescale 1ns/1ps
module aas_dec_model
import aas_pkg::*;
(
    // clock, reset, block status
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             busy,
    input  wire logic             done,
    // add request
    output logic                  start,
    output aas_pkg::aas_form_type form,
    output logic [15:0]           operand,
    output logic [3:0]            shift,
    output logic                  shift16,
    output logic [7:0]            rpt_count,
    output aas_pkg::aas_mem_type  prog_mem,
    output aas_pkg::aas_mem_type  opnd_mem,
    output logic                  same_block
);
    // form op shift s16 rpt pm om same gap
    logic [37:0] q[$];
    logic [37:0] cur_r   = '0;
    logic        start_r = 1'b0;
    logic        wait_r  = 1'b0;
    logic [1:0]  gap_r   = 2'h0;

    task automatic push(input logic [37:0] rq);
        q.push_back(rq);
    endtask : push

    assign start      = start_r;
    assign form       = aas_form_type'(cur_r[37:36]);
    assign operand    = cur_r[35:20];
    assign shift      = cur_r[19:16];
    assign shift16    = cur_r[15];
    assign rpt_count  = cur_r[14:7];
    assign prog_mem   = aas_mem_type'(cur_r[6:5]);
    assign opnd_mem   = aas_mem_type'(cur_r[4:3]);
    assign same_block = cur_r[2];

    // issue after gap, hold until done, then invert operand
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            start_r <= 1'b0;
            wait_r  <= 1'b0;
            gap_r   <= 2'h0;
        end
        else if (start_r && !busy)
        begin
            start_r <= 1'b0;
            wait_r  <= 1'b1;
        end
        else if (wait_r && done)
        begin
            wait_r         <= 1'b0;
            cur_r[35:20]   <= ~cur_r[35:20];
        end
        else if (!start_r && !wait_r && q.size() != 0)
        begin
            if (gap_r != q[0][1:0])
                gap_r <= gap_r + 2'h1;
            else
            begin
                gap_r   <= 2'h0;
                cur_r   <= q[0];
                start_r <= 1'b1;
                q.delete(0);
            end
        end
    end
endmodule : aas_dec_model

// ==== verification/aas_top_tb_top.sv ====
/*
 self-checking bench for the add-with-shift datapath.
 assumes aas_dec_model as decoder and a zero-wait apb slave.
*/
`timescale 1ns/1ps
module aas_top_tb_top;
    import aas_pkg::*;
    typedef struct packed
    {
        logic [31:0] acc;
        logic        c;
        logic        ov;
        logic [15:0] cyc;
    } aas_note_type;

    logic         pclk    = 1'b0;
    logic         presetn = 1'b0;
    logic         psel    = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite  = 1'b0;
    logic [11:0]  paddr   = 12'h000;
    logic [31:0]  pwdata  = 32'h0000_0000;
    logic [31:0]  prdata, accumulator, r, r2, v, rd, acc_e;
    logic [15:0]  operand;
    logic [7:0]   rpt_count;
    logic [3:0]   shift;
    logic [1:0]   f;
    logic         pready, pslverr, start, shift16, same_block, busy, done;
    logic         carry_flag, overflow_flag, er, c_e, ov_e, s16, sx, satm;
    aas_form_type form;
    aas_mem_type  prog_mem, opnd_mem;
    aas_note_type exp_q[$];
    aas_note_type nt;
    int           err_count    = 0;
    int           total_checks = 0;
    int           cyc_cnt      = 0;
    int           tick         = 0;
    int           seed         = 54;
    int           i, n, p, d;

    always #50 pclk = ~pclk;

    aas_top aas_top_inst (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .start, .form,
        .operand, .shift, .shift16, .rpt_count, .prog_mem, .opnd_mem,
        .same_block, .busy, .done, .accumulator, .carry_flag,
        .overflow_flag);
    aas_dec_model aas_dec_model_inst (.pclk, .presetn, .busy, .done,
        .start, .form, .operand, .shift, .shift16, .rpt_count,
        .prog_mem, .opnd_mem, .same_block);

    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [31:0] e, g);
        total_checks = total_checks + 1;
        if (g !== e)
        begin
            err_count = err_count + 1;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] wd, output logic [31:0] rdv, output logic erv);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdv = prdata;
        erv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd, rd, er);
    endtask : wr

    task automatic rdc(input logic [11:0] a, input logic [31:0] e,
        input logic ee);
        apb(1'b0, a, 32'h0, rd, er);
        chk("prdata", e, rd);
        chk("pslverr", 32'(ee), 32'(er));
    endtask : rdc

    function automatic logic [31:0] ext_op(input logic [1:0] fm,
        input logic [15:0] op, input logic [4:0] s, input logic sgn);
        logic [31:0] w;
        if (fm == 2'b01)
            return {16'h0000, op};
        w = sgn ? {{16{op[15]}}, op} : {16'h0000, op};
        return w << s;
    endfunction : ext_op

    task automatic add_step(input logic [31:0] w, input logic h16, om);
        logic [32:0] sum;
        logic        ovf;
        sum  = {1'b0, acc_e} + {1'b0, w};
        ovf  = (acc_e[31] == w[31]) && (sum[31] != acc_e[31]);
        c_e  = h16 ? (c_e | sum[32]) : sum[32];
        ov_e = ov_e | ovf;
        if (ovf && om)
            acc_e = acc_e[31] ? 32'h8000_0000 : 32'h7fff_ffff;
        else
            acc_e = sum[31:0];
    endtask : add_step

    function automatic int cyc_e(input logic [1:0] fm, pm, om,
        input logic sm, input int nn, pp, dd);
        int x;
        x = (pm == 2'b11) ? pp : 0;
        if (fm == 2'b01)
            return 1 + x;
        if (fm == 2'b10)
            return 2 + 2 * x;
        if (om == 2'b11)
            x = x + nn * dd;
        if ((pm == 2'b11 && om == 2'b11) || (pm == 2'b10 && om == 2'b10 && sm))
            x = x + 1;
        return nn + x;
    endfunction : cyc_e

    // results against oldest note, cycles counted from the taken edge
    always @(posedge pclk)
    begin
        if (done === 1'b1)
        begin
            nt = (exp_q.size() != 0) ? exp_q.pop_front() : '1;
            chk("accumulator", nt.acc, accumulator);
            chk("carry_flag", 32'(nt.c), 32'(carry_flag));
            chk("overflow_flag", 32'(nt.ov), 32'(overflow_flag));
            chk("cycles", 32'(nt.cyc), 32'(cyc_cnt));
        end
        cyc_cnt = (start === 1'b1 && busy === 1'b0) ? 0 : cyc_cnt + 1;
        tick = tick + 1;
        if (tick == 30000)
        begin
            err_count = err_count + 1;
            summarize();
        end
    end

    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rdc(AAS_OFS_CTRL, 32'h0, 1'b0);
        rdc(AAS_OFS_STATUS, 32'h0, 1'b0);
        rdc(AAS_OFS_ACC, 32'h0, 1'b0);
        rdc(AAS_OFS_WAIT, 32'h0, 1'b0);
        wr(AAS_OFS_WAIT, 32'h0000_0302);
        rdc(AAS_OFS_WAIT, 32'h0000_0302, 1'b0);
        apb(1'b1, 12'h010, 32'hffff_ffff, rd, er);
        chk("pslverr", 32'h1, 32'(er));
        rdc(12'h010, 32'h0, 1'b1);
        $display("test registers finished");
        for (i = 0; i < 96; i++)
        begin
            r     = $random(seed);
            r2    = $random(seed);
            f     = 2'(i / 32);
            s16   = (f != 2'b01) && (r[22:20] == 3'h0);
            sx    = r[23];
            satm  = r[24];
            p     = int'(r[26:25]);
            d     = int'(r[28:27]);
            n     = (f == 2'b00) ? int'(r[30:29]) + 1 : 1;
            c_e   = r[31];
            ov_e  = r2[5];
            acc_e = r2;
            wr(AAS_OFS_CTRL, {30'h0, satm, sx});
            wr(AAS_OFS_ACC, acc_e);
            wr(AAS_OFS_STATUS, {30'h0, ov_e, c_e});
            wr(AAS_OFS_WAIT, {16'h0, 6'h0, r[28:27], 6'h0, r[26:25]});
            v = ext_op(f, r[15:0], s16 ? 5'h10 : {1'b0, r[19:16]}, sx);
            repeat (n) add_step(v, s16, satm);
            exp_q.push_back({acc_e, c_e, ov_e,
                16'(cyc_e(f, i[4:3], i[2:1], i[0], n, p, d))});
            aas_dec_model_inst.push({f, r[15:0], r[19:16], s16, 8'(n - 1),
                i[4:3], i[2:1], i[0], r2[1:0]});
            for (int k = 0; k < 500 && exp_q.size() != 0; k++)
                @(posedge pclk);
            rdc(AAS_OFS_ACC, acc_e, 1'b0);
            rdc(AAS_OFS_STATUS, {29'h0, 1'b0, ov_e, c_e}, 1'b0);
        end
        chk("pending notes", 32'h0, 32'(exp_q.size()));
        $display("test adds finished");
        summarize();
    end
endmodule : aas_top_tb_top
